// ==== mic_pkg.sv ====
package mic_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [3:0] ADDR_GROUP_TWO   = 4'h0;
  localparam logic [3:0] ADDR_GROUP_THREE = 4'h4;
  localparam logic [3:0] ADDR_CONTROL     = 4'h8;
  localparam logic [3:0] ADDR_STATUS      = 4'hC;
  // group two field positions
  localparam int DMF_BIT  = 7;
  localparam int LVF_BIT  = 6;
  localparam int XPF_BIT  = 5;
  localparam int SMF_BIT  = 4;
  localparam int DME_BIT  = 3;
  localparam int LVE_BIT  = 2;
  localparam int XPE_BIT  = 1;
  localparam int SME_BIT  = 0;
  // group three field positions
  localparam int TAF_BIT  = 5;
  localparam int TPF_BIT  = 4;
  localparam int TAE_BIT  = 1;
  localparam int TPE_BIT  = 0;
  localparam logic [7:0] GROUP_THREE_MASK = 8'h33;
  // control register fields
  localparam int GIE_BIT  = 0;
  localparam int MF2E_BIT = 1;
  localparam int MF3E_BIT = 2;
  localparam int MF2F_BIT = 4;
  localparam int MF3F_BIT = 5;
  localparam logic [7:0] CONTROL_WMASK = 8'h37;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // vectors and stack
  localparam int PC_W    = 12;
  localparam int DEPTH   = 8;
  localparam int SP_W    = 4;
  localparam logic [PC_W-1:0] VEC_GROUP_TWO   = 12'h014;
  localparam logic [PC_W-1:0] VEC_GROUP_THREE = 12'h018;
  typedef enum logic [1:0] {
    MIC_SRC_NONE,
    MIC_SRC_TWO,
    MIC_SRC_THREE
  } mic_src_t;
endpackage

// ==== mic_stack.sv ====
`timescale 1ns/1ns
`default_nettype none
module mic_stack (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        push_i,
  input  wire logic                        pop_i,
  input  wire logic [mic_pkg::PC_W-1:0]    data_i,
  output logic      [mic_pkg::PC_W-1:0]    top_o,
  output logic                             full_o,
  output logic      [mic_pkg::SP_W-1:0]    level_o
);
  logic [mic_pkg::PC_W-1:0] mem [mic_pkg::DEPTH];
  logic [mic_pkg::SP_W-1:0] sp;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp <= '0;
    end else if (push_i && !full_o) begin
      sp <= sp + 4'h1;
    end else if (pop_i && sp != 4'h0) begin
      sp <= sp - 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (push_i && !full_o) begin
      mem[sp[2:0]] <= data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_o <= '0;
    end else if (pop_i && sp != 4'h0) begin
      top_o <= mem[sp[2:0] - 3'h1];
    end
  end
  assign full_o  = (sp == 4'h8);
  assign level_o = sp;
endmodule
`default_nettype wire

// ==== mic_wb_slave.sv ====
`timescale 1ns/1ns
`default_nettype none
module mic_wb_slave (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  output logic            ack_o,
  output logic            wr_o,
  output logic            rd_o
);
  // one access per cycle of the handshake, ack one edge after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end
  assign wr_o = 1'b0;
  assign rd_o = cyc_i && stb_i && !ack_o;
endmodule
`default_nettype wire

// ==== mic_irq_ctrl.sv ====
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - bit 7 group two holds data memory request
// - bit 6 group two holds low voltage request
// - bit 5 group two holds external peripheral request
// - bit 4 group two holds serial module request
// - bits 3..0 group two enable those sources
// - group three bits 5,4 hold timer requests
// - group three bits 1,0 enable timer requests
// - unused bits read zero, all reset zero
// - trigger sets flag regardless of enable
// - only enabled sources generate a call
// - global enable low blocks every interrupt
// - service pushes program counter on stack
// - service loads program counter with vector
// - return pops saved program counter
// - service clears global enable automatically
// - flags still set while globally blocked
// - no acknowledge while stack is full
// - newly set flag wakes from sleep or idle
// - grouped sources share a multi-function vector
// - a member flag newly set while its own enable is set sets its group flag
// - service clears group flag, not member flags
module mic_irq_ctrl (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [3:0]               adr_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  input  wire logic                     data_memory_event_i,
  input  wire logic                     low_voltage_event_i,
  input  wire logic                     ext_peripheral_event_i,
  input  wire logic                     serial_module_event_i,
  input  wire logic                     timer3_cmp_a_event_i,
  input  wire logic                     timer3_cmp_p_event_i,
  input  wire logic                     insn_boundary_i,
  input  wire logic                     return_from_interrupt_i,
  input  wire logic [mic_pkg::PC_W-1:0] next_pc_i,
  input  wire logic                     low_power_i,
  output logic                          pc_load_o,
  output logic      [mic_pkg::PC_W-1:0] pc_value_o,
  output logic                          wake_o,
  output logic                          stack_full_o
);
  logic [7:0] group_two;
  logic [7:0] group_three;
  logic       global_irq_enable;
  logic       mf2_enable;
  logic       mf3_enable;
  logic       mf2_flag;
  logic       mf3_flag;
  logic       req_take;
  logic       do_wr;
  logic       wr_unused;
  logic       pending_return;
  logic       pop_done;
  logic       stack_full;
  logic [mic_pkg::SP_W-1:0] stack_level;
  logic [mic_pkg::PC_W-1:0] stack_top;
  mic_pkg::mic_src_t next_src;
  logic       service;
  logic [5:0] ev_rise;
  logic [5:0] ev_prev;
  logic [5:0] member_set;

  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [7:0] nw,
                                            input logic       en);
    merge_byte = en ? nw : old;
  endfunction

  mic_wb_slave u_bus (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .ack_o (ack_o),
    .wr_o  (wr_unused),
    .rd_o  (req_take)
  );

  // write takes effect on the ack edge, as the master samples it there
  assign do_wr = cyc_i && stb_i && we_i && ack_o;

  // events are pulse-or-level; an edge marks a fresh trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_prev <= 6'h00;
    end else begin
      ev_prev <= {data_memory_event_i, low_voltage_event_i,
                  ext_peripheral_event_i, serial_module_event_i,
                  timer3_cmp_a_event_i, timer3_cmp_p_event_i};
    end
  end
  assign ev_rise = {data_memory_event_i, low_voltage_event_i,
                    ext_peripheral_event_i, serial_module_event_i,
                    timer3_cmp_a_event_i, timer3_cmp_p_event_i} & ~ev_prev;

  // group two: flags in the high nibble, enables in the low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      group_two <= mic_pkg::RESET_VALUE;
    end else begin
      logic [7:0] v;
      v = group_two;
      if (do_wr && adr_i == mic_pkg::ADDR_GROUP_TWO) begin
        v = merge_byte(v, dat_i[7:0], sel_i[0]);
      end
      // set wins over a software clear in the same cycle
      if (ev_rise[5]) v[mic_pkg::DMF_BIT] = 1'b1;
      if (ev_rise[4]) v[mic_pkg::LVF_BIT] = 1'b1;
      if (ev_rise[3]) v[mic_pkg::XPF_BIT] = 1'b1;
      if (ev_rise[2]) v[mic_pkg::SMF_BIT] = 1'b1;
      group_two <= v;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      group_three <= mic_pkg::RESET_VALUE;
    end else begin
      logic [7:0] v;
      v = group_three;
      if (do_wr && adr_i == mic_pkg::ADDR_GROUP_THREE) begin
        v = merge_byte(v, dat_i[7:0], sel_i[0]);
      end
      if (ev_rise[1]) v[mic_pkg::TAF_BIT] = 1'b1;
      if (ev_rise[0]) v[mic_pkg::TPF_BIT] = 1'b1;
      group_three <= v & mic_pkg::GROUP_THREE_MASK;
    end
  end

  // a member counts only when its own enable is set
  assign member_set[5] = ev_rise[5] && group_two[mic_pkg::DME_BIT];
  assign member_set[4] = ev_rise[4] && group_two[mic_pkg::LVE_BIT];
  assign member_set[3] = ev_rise[3] && group_two[mic_pkg::XPE_BIT];
  assign member_set[2] = ev_rise[2] && group_two[mic_pkg::SME_BIT];
  assign member_set[1] = ev_rise[1] && group_three[mic_pkg::TAE_BIT];
  assign member_set[0] = ev_rise[0] && group_three[mic_pkg::TPE_BIT];

  // group flags, set by members, cleared by service or software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf2_flag <= 1'b0;
    end else if (|member_set[5:2]) begin
      mf2_flag <= 1'b1;
    end else if (service && next_src == mic_pkg::MIC_SRC_TWO) begin
      mf2_flag <= 1'b0;
    end else if (do_wr && adr_i == mic_pkg::ADDR_CONTROL && sel_i[0]) begin
      mf2_flag <= dat_i[mic_pkg::MF2F_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf3_flag <= 1'b0;
    end else if (|member_set[1:0]) begin
      mf3_flag <= 1'b1;
    end else if (service && next_src == mic_pkg::MIC_SRC_THREE) begin
      mf3_flag <= 1'b0;
    end else if (do_wr && adr_i == mic_pkg::ADDR_CONTROL && sel_i[0]) begin
      mf3_flag <= dat_i[mic_pkg::MF3F_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf2_enable <= 1'b0;
      mf3_enable <= 1'b0;
    end else if (do_wr && adr_i == mic_pkg::ADDR_CONTROL && sel_i[0]) begin
      mf2_enable <= dat_i[mic_pkg::MF2E_BIT];
      mf3_enable <= dat_i[mic_pkg::MF3E_BIT];
    end
  end

  // priority: group two ahead of group three
  always_comb begin
    next_src = mic_pkg::MIC_SRC_NONE;
    if (mf2_flag && mf2_enable) begin
      next_src = mic_pkg::MIC_SRC_TWO;
    end else if (mf3_flag && mf3_enable) begin
      next_src = mic_pkg::MIC_SRC_THREE;
    end
  end

  // stall while the stack has no room; the flag stays for later
  assign service = insn_boundary_i && global_irq_enable &&
                   !stack_full &&
                   !return_from_interrupt_i &&
                   next_src != mic_pkg::MIC_SRC_NONE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable <= 1'b0;
    end else if (service) begin
      global_irq_enable <= 1'b0;
    end else if (do_wr && adr_i == mic_pkg::ADDR_CONTROL && sel_i[0]) begin
      global_irq_enable <= dat_i[mic_pkg::GIE_BIT];
    end
  end

  mic_stack u_stack (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .push_i  (service),
    .pop_i   (return_from_interrupt_i),
    .data_i  (next_pc_i),
    .top_o   (stack_top),
    .full_o  (stack_full),
    .level_o (stack_level)
  );

  // pc load is registered on the same edge as the push; a pop loads no pc
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_load_o      <= 1'b0;
      pc_value_o     <= '0;
      pending_return <= 1'b0;
    end else begin
      pending_return <= return_from_interrupt_i && stack_level != 4'h0;
      pc_load_o      <= service;
      if (service) begin
        pc_value_o <= (next_src == mic_pkg::MIC_SRC_TWO) ?
                      mic_pkg::VEC_GROUP_TWO :
                      mic_pkg::VEC_GROUP_THREE;
      end
    end
  end
  assign pop_done = pending_return;

  // wake only on a flag rising while in a low-power mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= low_power_i && (|ev_rise);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req_take && !we_i) begin
      if (adr_i == mic_pkg::ADDR_GROUP_TWO) begin
        dat_o <= {24'h000000, group_two};
      end else if (adr_i == mic_pkg::ADDR_GROUP_THREE) begin
        dat_o <= {24'h000000, group_three};
      end else if (adr_i == mic_pkg::ADDR_CONTROL) begin
        dat_o <= {26'h0000000, mf3_flag, mf2_flag, 1'b0,
                  mf3_enable, mf2_enable, global_irq_enable};
      end else if (adr_i == mic_pkg::ADDR_STATUS) begin
        dat_o <= {19'h00000, pop_done, stack_level, 3'h0, stack_top[4:0]};
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  assign stack_full_o = stack_full;
endmodule
`default_nettype wire

// ==== mic_irq_ctrl_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module mic_irq_ctrl_asserts (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     cyc_i,
  input wire logic                     stb_i,
  input wire logic                     ack_o,
  input wire logic                     data_memory_event_i,
  input wire logic                     insn_boundary_i,
  input wire logic                     return_from_interrupt_i,
  input wire logic                     low_power_i,
  input wire logic                     pc_load_o,
  input wire logic [mic_pkg::PC_W-1:0] pc_value_o,
  input wire logic                     wake_o,
  input wire logic                     stack_full_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_one_cycle: assert property (s_req |=> s_ack)
    else $error("ack not a single pulse one cycle after request");
  a_load_single: assert property (pc_load_o |=> !pc_load_o)
    else $error("vector load repeated without a new enable");
  a_vector_known: assert property (pc_load_o |->
    pc_value_o == mic_pkg::VEC_GROUP_TWO ||
    pc_value_o == mic_pkg::VEC_GROUP_THREE)
    else $error("vector value not a group vector");
  a_full_blocks: assert property (stack_full_o |=> !pc_load_o)
    else $error("service taken with full stack");
  a_load_boundary: assert property (pc_load_o |-> $past(insn_boundary_i))
    else $error("vector load without instruction boundary");
  a_push_fills: assert property ($rose(stack_full_o) |-> pc_load_o)
    else $error("stack filled without a service");
  a_pop_frees: assert property
    (stack_full_o && return_from_interrupt_i |=> !stack_full_o)
    else $error("return did not pop a full stack");
  a_wake_rise: assert property
    (low_power_i && $rose(data_memory_event_i) |-> ##[1:2] wake_o)
    else $error("no wake on event rise in low power");
  a_wake_cause: assert property
    (wake_o |-> $past(low_power_i) || $past(low_power_i, 2))
    else $error("wake outside low power");
endmodule
`default_nettype wire

// ==== mic_cpu_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module mic_cpu_model (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     pc_load_i,
  input  wire logic [mic_pkg::PC_W-1:0] pc_value_i,
  output logic                          insn_boundary_o,
  output logic      [mic_pkg::PC_W-1:0] next_pc_o
);
  // boundary only every other cycle, so a request may have to wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      insn_boundary_o <= 1'b0;
      next_pc_o <= 12'h000;
    end else begin
      insn_boundary_o <= ~insn_boundary_o;
      if (pc_load_i) begin
        next_pc_o <= pc_value_i + 12'h001;
      end else if (insn_boundary_o) begin
        next_pc_o <= next_pc_o + 12'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== mic_irq_ctrl_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module mic_irq_ctrl_test;
  logic        clk_i, rst_i, cyc, stb, we, ack, ret, lowp, ld, wake, full;
  logic        bnd;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, dout;
  logic [5:0]  ev;
  logic [11:0] npc, pcv;
  int          error_cnt, checks, nld, nwk;
  mic_irq_ctrl mic_irq_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .sel_i(4'hF), .adr_i(adr), .dat_i(wdat),
    .dat_o(dout), .ack_o(ack), .data_memory_event_i(ev[0]),
    .low_voltage_event_i(ev[1]), .ext_peripheral_event_i(ev[2]),
    .serial_module_event_i(ev[3]), .timer3_cmp_a_event_i(ev[4]),
    .timer3_cmp_p_event_i(ev[5]), .insn_boundary_i(bnd),
    .return_from_interrupt_i(ret), .next_pc_i(npc), .low_power_i(lowp),
    .pc_load_o(ld), .pc_value_o(pcv), .wake_o(wake), .stack_full_o(full));
  mic_cpu_model mic_cpu_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .pc_load_i(ld), .pc_value_i(pcv), .insn_boundary_o(bnd),
    .next_pc_o(npc));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (ld === 1'b1) nld++;
    if (wake === 1'b1) nwk++;
  end
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    // ack and read data are taken at the edge where ack is seen high
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) tmo();
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, exp);
    wb(1'b0, a, 8'h00);
    chk(rdat & m, exp);
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 6'h00;
  endtask
  task automatic pop;
    @(posedge clk_i);
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
  endtask
  task automatic no_load(input int n);
    int b;
    b = nld;
    repeat (n) @(negedge clk_i);
    chk(nld - b, 0);
  endtask
  task automatic wait_ld(input logic [11:0] v);
    int n;
    n = 0;
    while (ld !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    if (ld !== 1'b1) tmo();
    chk({20'h00000, pcv}, {20'h00000, v});
    @(negedge clk_i);
  endtask
  task automatic s_regs;
    rd(4'h0, 32'hFFFFFFFF, 32'h00);
    rd(4'h8, 32'hFFFFFFFF, 32'h00);
    wb(1'b1, 4'h4, 8'hFF);
    rd(4'h4, 32'hFFFFFFFF, 32'h33);
    wb(1'b1, 4'h4, 8'h00);
  endtask
  task automatic s_flags;
    pulse(6'h3F);
    no_load(6);
    rd(4'h0, 32'hFF, 32'hF0);
    rd(4'h4, 32'hFF, 32'h30);
    wb(1'b1, 4'h0, 8'h0F);
    rd(4'h0, 32'hFF, 32'h0F);
    wb(1'b1, 4'h4, 8'h00);
  endtask
  task automatic s_service;
    wb(1'b1, 4'h0, 8'h08);
    wb(1'b1, 4'h8, 8'h03);
    pulse(6'h04);
    no_load(6);
    wb(1'b1, 4'h8, 8'h02);
    pulse(6'h01);
    no_load(6);
    rd(4'h8, 32'hFF, 32'h12);
    wb(1'b1, 4'h8, 8'h13);
    wait_ld(mic_pkg::VEC_GROUP_TWO);
    rd(4'h8, 32'hFF, 32'h02);
    rd(4'h0, 32'hFF, 32'hA8);
    rd(4'hC, 32'hF00, 32'h100);
    pop();
    rd(4'hC, 32'hF00, 32'h000);
  endtask
  task automatic s_prio;
    wb(1'b1, 4'h0, 8'h08);
    wb(1'b1, 4'h4, 8'h02);
    wb(1'b1, 4'h8, 8'h06);
    pulse(6'h11);
    wb(1'b1, 4'h8, 8'h37);
    wait_ld(mic_pkg::VEC_GROUP_TWO);
    wb(1'b1, 4'h8, 8'h27);
    wait_ld(mic_pkg::VEC_GROUP_THREE);
    pop();
    pop();
  endtask
  task automatic s_full;
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, 4'h0, 8'h08);
      pulse(6'h01);
      wb(1'b1, 4'h8, 8'h13);
      if (i < 8) wait_ld(mic_pkg::VEC_GROUP_TWO);
    end
    chk({31'h0, full}, 32'h1);
    no_load(8);
    pop();
    wait_ld(mic_pkg::VEC_GROUP_TWO);
    repeat (8) pop();
    rd(4'hC, 32'hF00, 32'h000);
  endtask
  task automatic s_wake;
    int b;
    b = nwk;
    @(posedge clk_i);
    ev <= 6'h02;
    @(posedge clk_i);
    lowp <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk(nwk - b, 0);
    @(posedge clk_i);
    ev <= 6'h00;
    pulse(6'h09);
    repeat (4) @(negedge clk_i);
    chk(nwk - b, 1);
    @(posedge clk_i);
    lowp <= 1'b0;
  endtask
  initial begin
    error_cnt = 0;
    checks = 0;
    nld = 0;
    nwk = 0;
    rst_i = 1'b1;
    {cyc, stb, we, ret, lowp} = 5'h00;
    adr = 4'h0;
    wdat = 32'h00000000;
    ev = 6'h00;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs();
    s_flags();
    s_service();
    s_prio();
    s_full();
    s_wake();
    end_sim();
  end
endmodule
bind mic_irq_ctrl mic_irq_ctrl_asserts mic_irq_ctrl_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .data_memory_event_i(data_memory_event_i),
  .insn_boundary_i(insn_boundary_i),
  .return_from_interrupt_i(return_from_interrupt_i),
  .low_power_i(low_power_i), .pc_load_o(pc_load_o),
  .pc_value_o(pc_value_o), .wake_o(wake_o), .stack_full_o(stack_full_o));
`default_nettype wire
